// ---- rtl/pmacs_defines.svh ----
// Constants for the attachment-layer control and status register set.
`ifndef PMACS_DEFINES_SVH
`define PMACS_DEFINES_SVH

`define PMACS_MMD_ADDR 5'h01
`define PMACS_REG_CTRL1 16'h0000
`define PMACS_REG_STAT1 16'h0001
`define PMACS_REG_DEVS_LO 16'h0005
`define PMACS_REG_DEVS_HI 16'h0006

`define PMACS_CTRL1_RESET 16'h0000
`define PMACS_STAT1_RESET 16'h0002
`define PMACS_DEVS_LO_VAL 16'h008B
`define PMACS_DEVS_HI_VAL 16'hC000

`define PMACS_CTRL_SFT_RST_BIT 15
`define PMACS_CTRL_SFT_PD_BIT 11
`define PMACS_CTRL_LOOPBACK_BIT 0
`define PMACS_STAT_LINK_BIT 2
`define PMACS_STAT_PD_ABLE_BIT 1

`define PMACS_CLK_PERIOD_NS 10
`define PMACS_SOFT_RST_NS 2000
`define PMACS_SOFT_RST_CYCLES \
	((`PMACS_SOFT_RST_NS + `PMACS_CLK_PERIOD_NS - 1) / `PMACS_CLK_PERIOD_NS)
`define PMACS_SYNC_STAGES 2
`define PMACS_STRAP_SETTLE_CYCLES 3

`endif

// ---- rtl/pmacs_pkg.sv ----
// Types shared by the attachment-layer control and status register set.
`default_nettype none
package pmacs_pkg;

	typedef enum logic [1:0] {
		ST_STRAP_LOAD,
		ST_RUN,
		ST_SOFT_RESET
	} pmacs_state_e;

	typedef struct packed {
		pmacs_state_e state;
		logic [15:0] cnt;
		logic soft_rst;
		logic powerdown;
		logic loopback;
		logic link_ll;
		logic [15:0] rdata;
		logic rvalid;
	} pmacs_regs_s;

endpackage

`default_nettype wire

// ---- rtl/pmacs_sync.sv ----
// Multi-stage synchroniser for levels that arrive from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module pmacs_sync #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned STAGES = 2
) (
	input wire logic clock_i, // System clock.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	input wire logic [WIDTH-1:0] async_i, // Level from another domain.
	output logic [WIDTH-1:0] sync_o // Level after the last stage.
);

	typedef struct packed {
		logic [STAGES-1:0][WIDTH-1:0] stage;
	} pmacs_sync_s;

	pmacs_sync_s r_reg;
	pmacs_sync_s r_next;

	// Each stage only feeds the next; nothing else looks at the early stages.
	always_comb begin
		r_next.stage = {r_reg.stage[STAGES-2:0], async_i};
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign sync_o = r_reg.stage[STAGES-1];

endmodule

`default_nettype wire

// ---- rtl/pmacs_regs.sv ----
// Attachment-layer control and status registers behind the management port.
`timescale 1ns/1ps
`default_nettype none
`include "pmacs_defines.svh"

module pmacs_regs #(
	parameter int unsigned SOFT_RST_CYCLES = `PMACS_SOFT_RST_CYCLES,
	parameter int unsigned SYNC_STAGES = `PMACS_SYNC_STAGES
) (
	input wire logic clock_i, // System clock, 100 MHz.
	input wire logic rst_n_i, // Chip reset, asynchronous, active low.
	input wire logic [4:0] mgmt_dev_addr_i, // Management device address.
	input wire logic [15:0] mgmt_reg_addr_i, // Register address in the device.
	input wire logic mgmt_wr_i, // Write strobe, one cycle.
	input wire logic mgmt_rd_i, // Read strobe, one cycle.
	input wire logic [15:0] mgmt_wdata_i, // Write data.
	input wire logic port_powerdown_strap_i, // Strap pin for power-down default.
	input wire logic link_up_i, // Current link state from the receiver.
	output logic [15:0] mgmt_rdata_o, // Read data.
	output logic mgmt_rvalid_o, // Read data valid, one cycle.
	output logic chip_soft_reset_o, // Chip reinitialisation in progress.
	output logic attach_soft_powerdown_o, // Low-power mode request.
	output logic attach_local_loopback_en_o // Local loopback enable.
);

	localparam pmacs_pkg::pmacs_regs_s RESET_STATE = '{
		state: pmacs_pkg::ST_STRAP_LOAD,
		cnt: 16'(`PMACS_STRAP_SETTLE_CYCLES - 1),
		soft_rst: 1'h0,
		powerdown: 1'h0,
		loopback: 1'h0,
		link_ll: 1'h0,
		rdata: 16'h0000,
		rvalid: 1'h0
	};

	// Bit-selects need a named constant, not a bare literal.
	localparam logic [15:0] CTRL_DEFAULT = `PMACS_CTRL1_RESET;

	pmacs_pkg::pmacs_regs_s r_reg;
	pmacs_pkg::pmacs_regs_s r_next;

	logic strap_sync;
	logic busy;
	logic link_now;
	logic rd_ctrl;
	logic rd_stat;
	logic rd_any;
	logic wr_ctrl;

	// Address decode shared by the read and the write paths.
	function automatic logic reg_hit(input logic [4:0] dev, input logic [15:0] ra,
			input logic [15:0] target);
		return (dev == `PMACS_MMD_ADDR) && (ra == target);
	endfunction

	// Read word for one register address; unmapped addresses read zero.
	function automatic logic [15:0] read_word(input logic [15:0] ra, input logic rst_busy,
			input logic pd, input logic lb, input logic link);
		logic [15:0] w;
		w = 16'h0000;
		unique case (ra)
			`PMACS_REG_CTRL1: begin
				w[`PMACS_CTRL_SFT_RST_BIT] = rst_busy;
				w[`PMACS_CTRL_SFT_PD_BIT] = pd;
				w[`PMACS_CTRL_LOOPBACK_BIT] = lb;
			end
			`PMACS_REG_STAT1: begin
				w = `PMACS_STAT1_RESET;
				w[`PMACS_STAT_LINK_BIT] = link;
			end
			`PMACS_REG_DEVS_LO: w = `PMACS_DEVS_LO_VAL;
			`PMACS_REG_DEVS_HI: w = `PMACS_DEVS_HI_VAL;
			default: w = 16'h0000;
		endcase
		return w;
	endfunction

	// The strap is a pin, so it passes two flip-flops before use.
	pmacs_sync #(
		.WIDTH(1),
		.STAGES(SYNC_STAGES)
	) u_strap_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.async_i(port_powerdown_strap_i),
		.sync_o(strap_sync)
	);

	assign busy = (r_reg.state != pmacs_pkg::ST_RUN);
	assign link_now = r_reg.link_ll && link_up_i;
	assign rd_any = mgmt_rd_i && (mgmt_dev_addr_i == `PMACS_MMD_ADDR);
	assign rd_ctrl = mgmt_rd_i && reg_hit(mgmt_dev_addr_i, mgmt_reg_addr_i, `PMACS_REG_CTRL1);
	assign rd_stat = mgmt_rd_i && reg_hit(mgmt_dev_addr_i, mgmt_reg_addr_i, `PMACS_REG_STAT1);
	assign wr_ctrl = mgmt_wr_i && reg_hit(mgmt_dev_addr_i, mgmt_reg_addr_i, `PMACS_REG_CTRL1);

	always_comb begin
		r_next = r_reg;
		r_next.rvalid = 1'h0;

		// Latched-low link: any drop clears it, a status read reloads it.
		r_next.link_ll = r_reg.link_ll && link_up_i;
		if (rd_stat) begin
			r_next.link_ll = link_up_i;
		end

		// Reads are answered in every state, power-down included.
		if (rd_any) begin
			r_next.rdata = read_word(mgmt_reg_addr_i, busy, r_reg.powerdown, r_reg.loopback,
				link_now);
			r_next.rvalid = 1'h1;
		end

		unique case (r_reg.state)
			pmacs_pkg::ST_STRAP_LOAD: begin
				// Wait for the strap synchroniser to fill before sampling it.
				if (r_reg.cnt == 16'h0000) begin
					r_next.powerdown = strap_sync;
					r_next.state = pmacs_pkg::ST_RUN;
				end else begin
					r_next.cnt = r_reg.cnt - 16'h0001;
				end
			end
			pmacs_pkg::ST_RUN: begin
				if (wr_ctrl) begin
					// Only the writable bits are stored; reserved bits are dropped.
					r_next.powerdown = mgmt_wdata_i[`PMACS_CTRL_SFT_PD_BIT];
					r_next.loopback = mgmt_wdata_i[`PMACS_CTRL_LOOPBACK_BIT];
					if (mgmt_wdata_i[`PMACS_CTRL_SFT_RST_BIT]) begin
						r_next.state = pmacs_pkg::ST_SOFT_RESET;
						r_next.soft_rst = 1'h1;
						r_next.cnt = 16'(SOFT_RST_CYCLES - 1);
					end
				end
			end
			pmacs_pkg::ST_SOFT_RESET: begin
				if (r_reg.cnt == 16'h0000) begin
					// End of reinitialisation: power-down back to the strap, loopback to its reset default.
					r_next.state = pmacs_pkg::ST_RUN;
					r_next.soft_rst = 1'h0;
					r_next.powerdown = strap_sync;
					r_next.loopback = CTRL_DEFAULT[`PMACS_CTRL_LOOPBACK_BIT];
					r_next.link_ll = 1'h0;
				end else begin
					r_next.cnt = r_reg.cnt - 16'h0001;
				end
			end
			default: r_next.state = pmacs_pkg::ST_STRAP_LOAD;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r_reg <= RESET_STATE;
		end else begin
			r_reg <= r_next;
		end
	end

	assign mgmt_rdata_o = r_reg.rdata;
	assign mgmt_rvalid_o = r_reg.rvalid;
	assign chip_soft_reset_o = r_reg.soft_rst;
	assign attach_soft_powerdown_o = r_reg.powerdown;
	assign attach_local_loopback_en_o = r_reg.loopback;

	// Checks below watch only what this block drives.
	logic [15:0] hold_cnt;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_cnt <= 16'h0000;
		end else if (chip_soft_reset_o) begin
			hold_cnt <= hold_cnt + 16'h0001;
		end else begin
			hold_cnt <= 16'h0000;
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking

	default disable iff (!rst_n_i);

	soft_rst_start_a: assert property (
		(wr_ctrl && !busy && mgmt_wdata_i[`PMACS_CTRL_SFT_RST_BIT])
			|=> chip_soft_reset_o && !$past(chip_soft_reset_o))
		else $error("soft reset did not start after control write");

	soft_rst_len_a: assert property (
		$fell(chip_soft_reset_o) |-> hold_cnt == 16'(SOFT_RST_CYCLES))
		else $error("soft reset held for the wrong number of cycles");

	busy_read_a: assert property (
		rd_ctrl |=> mgmt_rvalid_o
			&& mgmt_rdata_o[`PMACS_CTRL_SFT_RST_BIT] == $past(busy))
		else $error("reset bit read does not match reset progress");

	pd_write_a: assert property (
		(wr_ctrl && !busy) |=> attach_soft_powerdown_o
			== $past(mgmt_wdata_i[`PMACS_CTRL_SFT_PD_BIT]))
		else $error("power-down did not follow control write");

	loopback_write_a: assert property (
		(wr_ctrl && !busy && !mgmt_wdata_i[`PMACS_CTRL_SFT_RST_BIT])
			|=> attach_local_loopback_en_o
				== $past(mgmt_wdata_i[`PMACS_CTRL_LOOPBACK_BIT]))
		else $error("loopback did not follow control write");

	pd_strap_a: assert property (
		$fell(chip_soft_reset_o) |-> attach_soft_powerdown_o == $past(strap_sync)
			&& !attach_local_loopback_en_o)
		else $error("control defaults not reloaded from strap");

	pd_read_a: assert property (
		(rd_any && attach_soft_powerdown_o) |=> mgmt_rvalid_o)
		else $error("read refused while powered down");

	ctrl_reserved_a: assert property (
		rd_ctrl |=> mgmt_rdata_o[14:12] == 3'h0 && mgmt_rdata_o[10:1] == 10'h000
			&& mgmt_rdata_o[0] == $past(attach_local_loopback_en_o))
		else $error("control reserved bits not zero");

	stat_fixed_a: assert property (
		rd_stat |=> mgmt_rdata_o[15:3] == 13'h0000 && mgmt_rdata_o[1:0] == 2'h2)
		else $error("status fixed bits wrong");

	link_latch_a: assert property (
		rd_stat ##1 mgmt_rdata_o[`PMACS_STAT_LINK_BIT] |-> $past(link_up_i))
		else $error("link bit read one while link was down");

	link_reload_a: assert property (
		(rd_stat && !busy) ##1 (rd_stat && !busy && link_up_i && $past(link_up_i))
			|=> mgmt_rdata_o[`PMACS_STAT_LINK_BIT])
		else $error("latched link did not reload after read");

	devs_low_a: assert property (
		(mgmt_rd_i && reg_hit(mgmt_dev_addr_i, mgmt_reg_addr_i, `PMACS_REG_DEVS_LO))
			|=> mgmt_rvalid_o && mgmt_rdata_o == 16'h008B)
		else $error("devices present low reads wrong");

	devs_high_a: assert property (
		(mgmt_rd_i && reg_hit(mgmt_dev_addr_i, mgmt_reg_addr_i, `PMACS_REG_DEVS_HI))
			|=> mgmt_rvalid_o && mgmt_rdata_o == 16'hC000)
		else $error("devices present high reads wrong");

	other_dev_a: assert property (
		(!mgmt_rd_i || mgmt_dev_addr_i != `PMACS_MMD_ADDR) |=> !mgmt_rvalid_o)
		else $error("answered a read for another device");

	rdata_hold_a: assert property (
		!rd_any |=> $stable(mgmt_rdata_o))
		else $error("read data changed without a read");

	rvalid_cause_a: assert property (
		mgmt_rvalid_o |-> $past(rd_any))
		else $error("read valid without a read strobe");

	pd_read_bit_a: assert property (
		rd_ctrl |=> mgmt_rdata_o[`PMACS_CTRL_SFT_PD_BIT]
			== $past(attach_soft_powerdown_o))
		else $error("power-down bit read does not match output");

	ctrl_hold_a: assert property (
		(!wr_ctrl && r_reg.state == pmacs_pkg::ST_RUN)
			|=> $stable(attach_soft_powerdown_o)
				&& $stable(attach_local_loopback_en_o))
		else $error("control outputs changed without a control write");

	busy_hold_a: assert property (
		(r_reg.state == pmacs_pkg::ST_SOFT_RESET && r_reg.cnt != 16'h0000)
			|=> chip_soft_reset_o && $stable(attach_soft_powerdown_o)
				&& $stable(attach_local_loopback_en_o))
		else $error("control changed while soft reset in progress");

	rst_count_a: assert property (
		(r_reg.state == pmacs_pkg::ST_SOFT_RESET && r_reg.cnt != 16'h0000)
			|=> r_reg.cnt == $past(r_reg.cnt) - 16'h0001)
		else $error("soft reset counter did not step down");

	strap_load_a: assert property (
		(r_reg.state == pmacs_pkg::ST_STRAP_LOAD && r_reg.cnt == 16'h0000)
			|=> attach_soft_powerdown_o == $past(strap_sync)
				&& !attach_local_loopback_en_o && !chip_soft_reset_o)
		else $error("power-down default not taken from strap");

	link_drop_a: assert property (
		!link_up_i |=> !r_reg.link_ll)
		else $error("link latch kept a dropped link");

endmodule

`default_nettype wire

// ---- verification/pmacs_host.sv ----
// Management host model that issues one-cycle read and write strobes.
`timescale 1ns/1ps
`default_nettype none

module pmacs_host (
	input wire logic clock_i, // System clock.
	output logic [4:0] dev_o, // Device address.
	output logic [15:0] addr_o, // Register address.
	output logic wr_o, // Write strobe.
	output logic rd_o, // Read strobe.
	output logic [15:0] wdata_o // Write data.
);
	initial begin
		dev_o = 5'h00;
		addr_o = 16'h0000;
		wr_o = 1'h0;
		rd_o = 1'h0;
		wdata_o = 16'h0000;
	end

	// Released address and data lines show the inverse so a stale value is never mistaken for a live one; strobes drop low.
	task automatic access(input logic w, input logic [4:0] dev, input logic [15:0] addr,
		input logic [15:0] data);
		@(negedge clock_i);
		dev_o = dev;
		addr_o = addr;
		wdata_o = data;
		wr_o = w;
		rd_o = !w;
		@(negedge clock_i);
		wr_o = 1'h0;
		rd_o = 1'h0;
		dev_o = ~dev;
		addr_o = ~addr;
		wdata_o = ~data;
	endtask
endmodule

`default_nettype wire

// ---- verification/test_pmacs_regs.sv ----
// Self-checking testbench for the attachment-layer control and status registers.
`timescale 1ns/1ps
`default_nettype none

module test_pmacs_regs;
	localparam int unsigned RST_CYC = 4;
	logic clock_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic strap = 1'h0;
	logic link_up = 1'h0;
	logic [4:0] dev;
	logic [15:0] addr, wdata, rdata, v;
	logic wr, rd, rvalid, soft_rst, pd, lb;
	logic [15:0] exp_q[$];
	int bad_count = 0;
	int checks = 0;
	int seed = 79;

	always #5 clock_i = ~clock_i;

	pmacs_host host (.clock_i(clock_i), .dev_o(dev), .addr_o(addr), .wr_o(wr), .rd_o(rd),
		.wdata_o(wdata));

	pmacs_regs #(.SOFT_RST_CYCLES(RST_CYC), .SYNC_STAGES(2)) uut (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.mgmt_dev_addr_i(dev),
		.mgmt_reg_addr_i(addr),
		.mgmt_wr_i(wr),
		.mgmt_rd_i(rd),
		.mgmt_wdata_i(wdata),
		.port_powerdown_strap_i(strap),
		.link_up_i(link_up),
		.mgmt_rdata_o(rdata),
		.mgmt_rvalid_o(rvalid),
		.chip_soft_reset_o(soft_rst),
		.attach_soft_powerdown_o(pd),
		.attach_local_loopback_en_o(lb)
	);

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		host.access(1'h0, 5'h01, a, 16'h0000);
	endtask

	task automatic wr_reg(input logic [4:0] d, input logic [15:0] a, input logic [15:0] data);
		host.access(1'h1, d, a, data);
	endtask

	task automatic end_sim();
		if (exp_q.size() != 0) bad_count++;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Every read answer is matched against the oldest expectation noted by the driver.
	always @(negedge clock_i) begin
		if (rvalid === 1'h1) begin
			if (exp_q.size() == 0) begin
				chk("unexpected rvalid", 16'h0001, 16'h0000);
			end else begin
				chk("rdata", rdata, exp_q.pop_front());
			end
		end
	end

	initial begin
		repeat (20) @(negedge clock_i);
		rst_n_i = 1'h1;
		repeat (6) @(negedge clock_i);
		rd_reg(16'h0000, 16'h0000);
		rd_reg(16'h0001, 16'h0002);
		rd_reg(16'h0005, 16'h008B);
		rd_reg(16'h0006, 16'hC000);
		rd_reg(16'h0002, 16'h0000);
		$display("test reset values done");
		v = 16'($random(seed));
		wr_reg(5'h01, 16'h0000, (v & 16'h7FFF) | 16'h0801);
		chk("powerdown", {15'h0000, pd}, 16'h0001);
		chk("loopback", {15'h0000, lb}, 16'h0001);
		wr_reg(5'h02, 16'h0000, 16'h0000);
		wr_reg(5'h01, 16'h0001, 16'hFFFF);
		rd_reg(16'h0000, 16'h0801);
		rd_reg(16'h0001, 16'h0002);
		host.access(1'h0, 5'h02, 16'h0000, 16'h0000);
		$display("test control write done");
		link_up = 1'h1;
		rd_reg(16'h0001, 16'h0002);
		rd_reg(16'h0001, 16'h0006);
		link_up = 1'h0;
		@(negedge clock_i);
		link_up = 1'h1;
		rd_reg(16'h0001, 16'h0002);
		rd_reg(16'h0001, 16'h0006);
		$display("test link latch done");
		strap = 1'h1;
		wr_reg(5'h01, 16'h0000, 16'h8000);
		chk("soft reset", {15'h0000, soft_rst}, 16'h0001);
		rd_reg(16'h0000, 16'h8000);
		repeat (RST_CYC + 2) @(negedge clock_i);
		chk("soft reset", {15'h0000, soft_rst}, 16'h0000);
		chk("powerdown", {15'h0000, pd}, 16'h0001);
		rd_reg(16'h0000, 16'h0800);
		rd_reg(16'h0001, 16'h0002);
		$display("test soft reset done");
		// Let the monitor take the last answer before the queue is judged.
		@(negedge clock_i);
		end_sim();
	end

	// The sequence needs under a hundred cycles; this limit only cuts a hang short.
	initial begin
		#20000;
		bad_count++;
		end_sim();
	end
endmodule

`default_nettype wire
